// [logic/iene_core.sv]
`default_nettype none
module iene_core
	import iene_pkg::*;
(
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        clk_en,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	// interrupt request pins
	input  wire logic        nmi_req_pin,
	input  wire logic        irq_req_pin,
	// stack memory write port and acknowledges
	output iene_mem_type     mem_wr,
	output logic             irq_ack,
	output logic             nmi_ack
);

	// ---------------------------------------------------------------
	// request synchronisers
	// ---------------------------------------------------------------
	logic [1:0] nmi_sync_r;
	logic [1:0] irq_sync_r;
	logic       nmi_prev_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			nmi_sync_r <= 2'h0;
			irq_sync_r <= 2'h0;
			nmi_prev_r <= 1'b0;
		end else if (clk_en) begin
			nmi_sync_r <= {nmi_sync_r[0], nmi_req_pin};
			irq_sync_r <= {irq_sync_r[0], irq_req_pin};
			nmi_prev_r <= nmi_sync_r[1];
		end
	end

	// ---------------------------------------------------------------
	// register access decode
	// ---------------------------------------------------------------
	logic acc;
	logic wr;
	logic [31:0] wd;
	assign acc = psel && penable && clk_en;
	assign wr  = acc && pwrite;
	assign wd  = pwdata;

	logic do_unmask, do_maskoff, do_nmret, do_nmret_mr;
	logic do_setmix, do_clrmix, do_ldair, do_bound;
	assign do_unmask   = wr && paddr == REG_CTRL && wd[CTL_UNMASK];
	assign do_maskoff  = wr && paddr == REG_CTRL && wd[CTL_MASKOFF];
	assign do_nmret    = wr && paddr == REG_CTRL && wd[CTL_NMRET];
	assign do_nmret_mr = wr && paddr == REG_CTRL && wd[CTL_NMRET_MR];
	assign do_setmix   = wr && paddr == REG_CTRL && wd[CTL_SETMIX];
	assign do_clrmix   = wr && paddr == REG_CTRL && wd[CTL_CLRMIX];
	assign do_ldair    = wr && paddr == REG_CTRL && wd[CTL_LDAIR];
	assign do_bound    = wr && paddr == REG_CTRL && wd[CTL_BOUNDARY];

	// ---------------------------------------------------------------
	// architectural state
	// ---------------------------------------------------------------
	logic        live_irq_enable_flag_r;
	logic        saved_irq_enable_flag_r;
	logic        mixed_mode_control_r;
	logic        wide_address_mode_bit_r;
	logic        parity_r;
	logic        hold_r;
	logic        nmi_pend_r;
	logic [23:0] pc_r;
	logic [15:0] short_stack_pointer_r;
	logic [23:0] long_stack_pointer_r;
	logic [7:0]  upper_address_base_r;
	logic [7:0]  pop_byte_r;
	iene_state_type state_r;
	logic [1:0]  cnt_r;
	logic        use_long_r;
	logic        push_mode_r;
	logic        pop_wide_r;

	logic busy;
	logic take_nmi;
	logic take_irq;
	assign busy = state_r != IENE_IDLE;
	// nonmaskable first, only at a boundary
	// boundary sampling priority
	assign take_nmi = do_bound && !busy && (nmi_pend_r || (nmi_sync_r[1] && !nmi_prev_r));
	assign take_irq = do_bound && !busy && !take_nmi && irq_sync_r[1]
		&& live_irq_enable_flag_r && !hold_r;

	// edge seen while busy or between boundaries is remembered
	// nonmaskable never lost
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			nmi_pend_r <= 1'b0;
		end else if (clk_en) begin
			// a fresh edge behind a taken pending one must stay pending
			if (nmi_sync_r[1] && !nmi_prev_r && (nmi_pend_r || !take_nmi)) begin
				nmi_pend_r <= 1'b1;
			end else if (take_nmi) begin
				nmi_pend_r <= 1'b0;
			end
		end
	end

	// ---------------------------------------------------------------
	// enable flags
	// ---------------------------------------------------------------
	// reset clears both
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			live_irq_enable_flag_r  <= 1'b0;
			saved_irq_enable_flag_r <= 1'b0;
		end else if (clk_en) begin
			if (take_nmi) begin
				saved_irq_enable_flag_r <= live_irq_enable_flag_r;
				live_irq_enable_flag_r  <= 1'b0;
			end else if (take_irq) begin
				live_irq_enable_flag_r  <= 1'b0;
				saved_irq_enable_flag_r <= 1'b0;
			end else if ((do_nmret || do_nmret_mr) && !busy) begin
				live_irq_enable_flag_r <= saved_irq_enable_flag_r;
			end else if (do_unmask) begin
				live_irq_enable_flag_r  <= 1'b1;
				saved_irq_enable_flag_r <= 1'b1;
			end else if (do_maskoff) begin
				live_irq_enable_flag_r  <= 1'b0;
				saved_irq_enable_flag_r <= 1'b0;
			end
		end
	end

	// one further boundary must pass before maskable acceptance
	// one-instruction delay
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hold_r <= 1'b0;
		end else if (clk_en) begin
			if (do_unmask) begin
				hold_r <= 1'b1;
			end else if (do_bound) begin
				hold_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			parity_r <= 1'b0;
		end else if (clk_en && do_ldair) begin
			parity_r <= saved_irq_enable_flag_r;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mixed_mode_control_r <= 1'b0;
		end else if (clk_en) begin
			if (do_setmix) begin
				mixed_mode_control_r <= 1'b1;
			end else if (do_clrmix) begin
				mixed_mode_control_r <= 1'b0;
			end
		end
	end

	// ---------------------------------------------------------------
	// entry and return sequencer, one stack byte per cycle
	// ---------------------------------------------------------------
	logic [7:0] push_byte;
	always_comb begin
		unique case (cnt_r)
			CNT_THREE: push_byte = pc_r[23:16];
			CNT_TWO:   push_byte = pc_r[15:8];
			default:   push_byte = pc_r[7:0];
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r                 <= IENE_IDLE;
			cnt_r                   <= CNT_ZERO;
			use_long_r              <= 1'b0;
			push_mode_r             <= 1'b0;
			pop_wide_r              <= 1'b0;
			wide_address_mode_bit_r <= 1'b0;
			pc_r                    <= 24'h000000;
			short_stack_pointer_r   <= 16'h0000;
			long_stack_pointer_r    <= 24'h000000;
			upper_address_base_r    <= 8'h00;
			mem_wr                  <= '0;
		end else if (clk_en) begin
			mem_wr.valid <= 1'b0;
			if (wr && !busy && paddr == REG_PC) begin
				pc_r <= wd[23:0];
			end
			if (wr && !busy && paddr == REG_SSP) begin
				short_stack_pointer_r <= wd[15:0];
			end
			if (wr && !busy && paddr == REG_LSP) begin
				long_stack_pointer_r <= wd[23:0];
			end
			if (wr && !busy && paddr == REG_BASE) begin
				upper_address_base_r <= wd[7:0];
			end
			if (wr && !busy && paddr == REG_CTRL && wd[CTL_WIDE]) begin
				wide_address_mode_bit_r <= 1'b1;
			end
			unique case (state_r)
				IENE_IDLE: begin
					if (take_nmi || take_irq) begin
						state_r     <= IENE_PUSH;
						use_long_r  <= wide_address_mode_bit_r || mixed_mode_control_r;
						push_mode_r <= mixed_mode_control_r;
						cnt_r       <= wide_address_mode_bit_r ? CNT_THREE : CNT_TWO;
					end else if (do_nmret_mr) begin
						state_r <= IENE_POPM;
					end else if (do_nmret) begin
						state_r    <= IENE_POPA;
						pop_wide_r <= wide_address_mode_bit_r;
						cnt_r      <= wide_address_mode_bit_r ? CNT_THREE : CNT_TWO;
					end
				end
				IENE_PUSH: begin
					mem_wr.valid <= 1'b1;
					mem_wr.data  <= push_byte;
					if (use_long_r) begin
						mem_wr.addr          <= long_stack_pointer_r - 24'h000001;
						long_stack_pointer_r <= long_stack_pointer_r - 24'h000001;
					end else begin
						mem_wr.addr           <= {upper_address_base_r,
							short_stack_pointer_r - 16'h0001};
						short_stack_pointer_r <= short_stack_pointer_r - 16'h0001;
					end
					cnt_r <= cnt_r - CNT_ONE;
					if (cnt_r == CNT_ONE) begin
						state_r <= push_mode_r ? IENE_MODE : IENE_IDLE;
						if (!push_mode_r) begin
							pc_r <= wide_address_mode_bit_r ? NMI_VECTOR
								: {pc_r[23:16], NMI_VECTOR[15:0]};
						end
					end
				end
				IENE_MODE: begin
					mem_wr.valid         <= 1'b1;
					mem_wr.addr          <= long_stack_pointer_r - 24'h000001;
					mem_wr.data          <= wide_address_mode_bit_r ? MODE_WIDE : MODE_SHORT;
					long_stack_pointer_r <= long_stack_pointer_r - 24'h000001;
					wide_address_mode_bit_r <= 1'b1;
					pc_r                    <= NMI_VECTOR;
					state_r                 <= IENE_IDLE;
				end
				IENE_POPM: begin
					wide_address_mode_bit_r <= pop_byte_r == MODE_WIDE;
					pop_wide_r              <= pop_byte_r == MODE_WIDE;
					long_stack_pointer_r    <= long_stack_pointer_r + 24'h000001;
					cnt_r                   <= pop_byte_r == MODE_WIDE ? CNT_THREE : CNT_TWO;
					state_r                 <= IENE_POPA;
				end
				IENE_POPA: begin
					// popped address bytes are not loaded into the pc; only the stack pointer advances
					if (pop_wide_r) begin
						long_stack_pointer_r <= long_stack_pointer_r + 24'h000001;
					end else begin
						short_stack_pointer_r <= short_stack_pointer_r + 16'h0001;
					end
					cnt_r <= cnt_r - CNT_ONE;
					if (cnt_r == CNT_ONE) begin
						state_r <= IENE_IDLE;
					end
				end
				default: state_r <= IENE_IDLE;
			endcase
		end
	end

	// byte that software presents as the next stack read
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pop_byte_r <= 8'h00;
		end else if (clk_en && wr && paddr == REG_POP) begin
			pop_byte_r <= wd[7:0];
		end
	end

	// ---------------------------------------------------------------
	// acknowledges and apb read path
	// ---------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_ack <= 1'b0;
			nmi_ack <= 1'b0;
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= RD_ZERO;
		end else if (clk_en) begin
			irq_ack <= take_irq;
			nmi_ack <= take_nmi;
			// no wait state: answer registered on the setup cycle
			pready  <= psel && !penable;
			pslverr <= 1'b0;
			prdata  <= RD_ZERO;
			if (psel && !penable && !pwrite) begin
				unique case (paddr)
					REG_STATUS: begin
						prdata[ST_LIVE]   <= live_irq_enable_flag_r;
						prdata[ST_SAVED]  <= saved_irq_enable_flag_r;
						prdata[ST_MIXED]  <= mixed_mode_control_r;
						prdata[ST_WIDE]   <= wide_address_mode_bit_r;
						prdata[ST_PARITY] <= parity_r;
						prdata[ST_BUSY]   <= busy;
						prdata[ST_HOLD]   <= hold_r;
						prdata[ST_NMIS]   <= nmi_pend_r;
						prdata[ST_MIS]    <= irq_sync_r[1];
					end
					REG_PC:   prdata[23:0] <= pc_r;
					REG_SSP:  prdata[15:0] <= short_stack_pointer_r;
					REG_LSP:  prdata[23:0] <= long_stack_pointer_r;
					REG_BASE: prdata[7:0]  <= upper_address_base_r;
					REG_POP:  prdata[7:0]  <= pop_byte_r;
					REG_CTRL: prdata       <= RD_ZERO;
					default:  pslverr      <= 1'b1;
				endcase
			end
		end
	end

endmodule
`default_nettype wire

// [shared/iene_pkg.sv]
`default_nettype none
package iene_pkg;

	// ---------------------------------------------------------------
	// address map
	// ---------------------------------------------------------------
	localparam logic [11:0] REG_CTRL   = 12'h000;
	localparam logic [11:0] REG_STATUS = 12'h004;
	localparam logic [11:0] REG_PC     = 12'h008;
	localparam logic [11:0] REG_SSP    = 12'h00C;
	localparam logic [11:0] REG_LSP    = 12'h010;
	localparam logic [11:0] REG_BASE   = 12'h014;
	localparam logic [11:0] REG_POP    = 12'h018;

	// ---------------------------------------------------------------
	// control register bit positions (write 1 = execute)
	// ---------------------------------------------------------------
	localparam int CTL_UNMASK   = 0;
	localparam int CTL_MASKOFF  = 1;
	localparam int CTL_NMRET    = 2;
	localparam int CTL_NMRET_MR = 3;
	localparam int CTL_SETMIX   = 4;
	localparam int CTL_CLRMIX   = 5;
	localparam int CTL_LDAIR    = 6;
	localparam int CTL_BOUNDARY = 7;
	localparam int CTL_WIDE     = 8;

	// ---------------------------------------------------------------
	// status register bit positions
	// ---------------------------------------------------------------
	localparam int ST_LIVE   = 0;
	localparam int ST_SAVED  = 1;
	localparam int ST_MIXED  = 2;
	localparam int ST_WIDE   = 3;
	localparam int ST_PARITY = 4;
	localparam int ST_BUSY   = 5;
	localparam int ST_HOLD   = 6;
	localparam int ST_NMIS   = 7;
	localparam int ST_MIS    = 8;

	// ---------------------------------------------------------------
	// fixed values
	// ---------------------------------------------------------------
	localparam logic [23:0] NMI_VECTOR  = 24'h000066;
	localparam logic [7:0]  MODE_WIDE   = 8'h03;
	localparam logic [7:0]  MODE_SHORT  = 8'h02;
	localparam logic [31:0] RD_ZERO     = 32'h00000000;
	localparam logic [1:0]  CNT_ONE     = 2'h1;
	localparam logic [1:0]  CNT_TWO     = 2'h2;
	localparam logic [1:0]  CNT_THREE   = 2'h3;
	localparam logic [1:0]  CNT_ZERO    = 2'h0;

	typedef enum logic [2:0] {
		IENE_IDLE = 3'b000,
		IENE_PUSH = 3'b001,
		IENE_MODE = 3'b011,
		IENE_POPM = 3'b010,
		IENE_POPA = 3'b110
	} iene_state_type;

	// one memory write towards the stack
	typedef struct packed {
		logic        valid;
		logic [23:0] addr;
		logic [7:0]  data;
	} iene_mem_type;

endpackage
`default_nettype wire

// [dv/iene_periph.sv]
`default_nettype none
module iene_periph
(
	// clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// bench commands
	input  wire logic nmi_fire,
	input  wire logic irq_raise,
	// service acknowledge
	input  wire logic irq_ack,
	// request pins
	output logic      nmi_req_pin,
	output logic      irq_req_pin
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [1:0] nmi_cnt_r;
	logic       irq_r;
	// edge held three cycles so the two-stage sync cannot miss it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			nmi_cnt_r <= 2'h0;
		else if (nmi_fire)
			nmi_cnt_r <= 2'h3;
		else if (nmi_cnt_r != 2'h0)
			nmi_cnt_r <= nmi_cnt_r - 2'h1;
	end
	// level request dropped only once serviced
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			irq_r <= 1'b0;
		else if (irq_raise)
			irq_r <= 1'b1;
		else if (irq_ack)
			irq_r <= 1'b0;
	end
	assign nmi_req_pin = nmi_cnt_r != 2'h0;
	assign irq_req_pin = irq_r;
endmodule
`default_nettype wire

// [dv/iene_core_asserts.sv]
`default_nettype none
module iene_core_asserts
	import iene_pkg::*;
(
	// clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic         clk_en,
	// apb
	input  wire logic         psel,
	input  wire logic         penable,
	input  wire logic         pwrite,
	input  wire logic [11:0]  paddr,
	input  wire logic [31:0]  pwdata,
	input  wire logic         pready,
	input  wire logic [31:0]  prdata,
	input  wire logic         pslverr,
	// requests and stack side
	input  wire logic         nmi_req_pin,
	input  wire logic         irq_req_pin,
	input  wire iene_mem_type mem_wr,
	input  wire logic         irq_ack,
	input  wire logic         nmi_ack
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// --------------------------------
	// enable flag shadow
	// --------------------------------
	logic wc;
	logic lv_r;
	logic sv_r;
	logic hd_r;
	assign wc = psel && penable && pready && pwrite && paddr == REG_CTRL;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lv_r <= 1'b0;
			sv_r <= 1'b0;
		end else if (irq_ack || (wc && pwdata[CTL_MASKOFF])) begin
			lv_r <= 1'b0;
			sv_r <= 1'b0;
		end else if (wc && pwdata[CTL_UNMASK]) begin
			lv_r <= 1'b1;
			sv_r <= 1'b1;
		end else if (nmi_ack) begin
			sv_r <= lv_r;
			lv_r <= 1'b0;
		end else if (wc && (pwdata[CTL_NMRET] || pwdata[CTL_NMRET_MR]))
			lv_r <= sv_r;
	end
	// hold-off lasts until the next completed instruction
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			hd_r <= 1'b0;
		else if (wc && pwdata[CTL_UNMASK])
			hd_r <= 1'b1;
		else if (wc && pwdata[CTL_BOUNDARY])
			hd_r <= 1'b0;
	end
	// --------------------------------
	// assertions
	// --------------------------------
	a_pready_single: assert property (pready |=> !pready)
		else $error("pready held past one cycle");
	a_answer_setup: assert property (psel && !penable |=> pready)
		else $error("no answer after setup");
	a_slverr_read: assert property (pslverr |-> pready && !pwrite)
		else $error("slave error outside a read answer");
	a_ack_boundary: assert property ((nmi_ack || irq_ack) |-> $past(wc && pwdata[CTL_BOUNDARY]))
		else $error("acknowledge without instruction boundary");
	a_ack_exclusive: assert property (!(nmi_ack && irq_ack))
		else $error("both requests acknowledged together");
	a_nmi_pulse: assert property (nmi_ack |=> !nmi_ack)
		else $error("nonmaskable acknowledge too long");
	a_push_follows: assert property (nmi_ack |-> ##[0:2] mem_wr.valid)
		else $error("no stack push after nonmaskable entry");
	a_irq_gate: assert property (irq_ack |-> $past(lv_r && !hd_r))
		else $error("maskable request taken while masked");
	c_nmi: cover property (nmi_ack);
	c_irq: cover property (irq_ack);
	c_err: cover property (pready && pslverr);
	c_mode: cover property (mem_wr.valid && mem_wr.data == MODE_WIDE);
endmodule
`default_nettype wire

// [dv/test_interrupt_enable_and_nmi_entry.sv]
`default_nettype none
bind iene_core iene_core_asserts i_iene_core_asserts (
	.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.pready(pready), .prdata(prdata), .pslverr(pslverr),
	.nmi_req_pin(nmi_req_pin), .irq_req_pin(irq_req_pin), .mem_wr(mem_wr),
	.irq_ack(irq_ack), .nmi_ack(nmi_ack)
);
module test_interrupt_enable_and_nmi_entry
	import iene_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	// --------------------------------
	// signals
	// --------------------------------
	logic         pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, se;
	logic         nmi_req_pin, irq_req_pin, irq_ack, nmi_ack, nmi_fire, irq_raise;
	logic [11:0]  paddr;
	logic [31:0]  pwdata, prdata, s;
	logic [31:0]  pq [$];
	iene_mem_type mem_wr;
	int           failures, checks, irq_n, nmi_n;
	iene_core i_iene_core (
		.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .pslverr(pslverr),
		.nmi_req_pin(nmi_req_pin), .irq_req_pin(irq_req_pin), .mem_wr(mem_wr),
		.irq_ack(irq_ack), .nmi_ack(nmi_ack)
	);
	iene_periph i_iene_periph (
		.pclk(pclk), .presetn(presetn), .nmi_fire(nmi_fire), .irq_raise(irq_raise),
		.irq_ack(irq_ack), .nmi_req_pin(nmi_req_pin), .irq_req_pin(irq_req_pin)
	);
	always #2.5 pclk = ~pclk;
	always @(posedge pclk) begin
		if (irq_ack === 1'b1)
			irq_n++;
		if (nmi_ack === 1'b1)
			nmi_n++;
		if (mem_wr.valid === 1'b1)
			pq.push_back({mem_wr.addr, mem_wr.data});
	end
	// --------------------------------
	// tasks
	// --------------------------------
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			failures++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic conclude();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// only the watchdog ends a wait for the answer
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		s = prdata;
		se = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic ctl(input logic [31:0] d);
		apb(1'b1, REG_CTRL, d);
	endtask
	task automatic poll(input int b, input logic v);
		int n;
		n = 0;
		do begin
			apb(1'b0, REG_STATUS, 32'h0);
			n++;
		end while (s[b] !== v && n < 40);
		chk("status poll", 32'(v), 32'(s[b]));
	endtask
	task automatic sts(input string nm, input logic [3:0] e);
		apb(1'b0, REG_STATUS, 32'h0);
		chk(nm, 32'(e), 32'(s[3:0]));
	endtask
	task automatic bnd();
		ctl(32'h1 << CTL_BOUNDARY);
		poll(ST_BUSY, 1'b0);
	endtask
	task automatic nmi();
		@(posedge pclk);
		nmi_fire <= 1'b1;
		@(posedge pclk);
		nmi_fire <= 1'b0;
		poll(ST_NMIS, 1'b1);
	endtask
	task automatic rst();
		presetn <= 1'b0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
	endtask
	task automatic nmi_case(input logic w, input logic m);
		logic [7:0]  eb [$];
		logic [23:0] pc;
		logic [23:0] sp;
		int          n0;
		pc = w ? 24'hABCDEF : 24'h001234;
		sp = (w | m) ? 24'h004000 : 24'h5A0200;
		ctl((32'(w) << CTL_UNMASK) | (32'(!w) << CTL_MASKOFF) | (32'(m) << CTL_SETMIX)
			| (32'(!m) << CTL_CLRMIX) | (32'(w) << CTL_WIDE));
		sts("flags set", {w, m, w, w});
		apb(1'b1, REG_PC, 32'(pc));
		apb(1'b1, REG_SSP, 32'h00000200);
		apb(1'b1, REG_LSP, 32'h00004000);
		apb(1'b1, REG_BASE, 32'h0000005A);
		pq.delete();
		n0 = nmi_n;
		nmi();
		bnd();
		chk("nmi taken", 32'(n0 + 1), 32'(nmi_n));
		sts("nmi entry", {w | m, m, w, 1'b0});
		if (w)
			eb.push_back(pc[23:16]);
		eb.push_back(pc[15:8]);
		eb.push_back(pc[7:0]);
		if (m)
			eb.push_back(w ? MODE_WIDE : MODE_SHORT);
		chk("push count", 32'(eb.size()), 32'(pq.size()));
		foreach (eb[k])
			chk("push", {sp - 24'(k + 1), eb[k]}, pq[k]);
		apb(1'b0, REG_PC, 32'h0);
		chk("vector", (w | m) ? 32'(NMI_VECTOR) : 32'h00000066,
			(w | m) ? s : {16'h0000, s[15:0]});
		ctl(32'h1 << CTL_LDAIR);
		apb(1'b0, REG_STATUS, 32'h0);
		chk("parity", 32'(w), 32'(s[ST_PARITY]));
		if (m)
			apb(1'b1, REG_POP, w ? 32'(MODE_SHORT) : 32'(MODE_WIDE));
		ctl(32'h1 << (m ? CTL_NMRET_MR : CTL_NMRET));
		poll(ST_BUSY, 1'b0);
		sts("nmi return", {m ? !w : w, m, w, w});
	endtask
	// --------------------------------
	// tests
	// --------------------------------
	initial begin
		#100000;
		failures++;
		conclude();
	end
	initial begin
		{pclk, presetn, psel, penable, pwrite, nmi_fire, irq_raise} = 7'h00;
		{paddr, pwdata, failures, checks, irq_n, nmi_n} = '0;
		clk_en = 1'b1;
		rst();
		sts("reset flags", 4'h0);
		apb(1'b0, 12'h01C, 32'h0);
		chk("unmapped", 32'h1, 32'(se));
		@(posedge pclk);
		irq_raise <= 1'b1;
		@(posedge pclk);
		irq_raise <= 1'b0;
		bnd();
		chk("irq masked", 32'h0, 32'(irq_n));
		ctl(32'h1 << CTL_UNMASK);
		apb(1'b0, REG_STATUS, 32'h0);
		chk("hold after unmask", 32'h1, 32'(s[ST_HOLD]));
		bnd();
		chk("irq held", 32'h0, 32'(irq_n));
		nmi();
		bnd();
		chk("irq behind nmi", 32'h0, 32'(irq_n));
		ctl(32'h1 << CTL_NMRET);
		poll(ST_BUSY, 1'b0);
		bnd();
		chk("irq taken", 32'h1, 32'(irq_n));
		clk_en <= 1'b0;
		repeat (4) @(posedge pclk);
		clk_en <= 1'b1;
		sts("irq entry", 4'h0);
		nmi_case(1'b0, 1'b0);
		nmi_case(1'b1, 1'b0);
		nmi_case(1'b1, 1'b1);
		nmi_case(1'b0, 1'b1);
		ctl(32'h1 << CTL_UNMASK);
		rst();
		sts("second reset", 4'h0);
		conclude();
	end
endmodule
`default_nettype wire
